//--- adc_conversion_sequencer.v
// conversion sequencer: start detection, busy flag, clock divider, 4+10 tick timing
// assumes a single-cycle register port on clk_sys_i; analog result arrives on sample_data_i
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "adc_seq_consts.vh"
module adc_conversion_sequencer (
   input wire clk_sys_i, // system clock, 50 MHz
   input wire rst_n_i, // asynchronous reset, active low
   input wire [1:0] addr_i, // register index
   input wire [7:0] wdata_i, // write data
   input wire wr_i, // write strobe
   input wire rd_i, // read strobe
   output reg [7:0] rdata_o, // read data, cycle after rd_i
   input wire [9:0] sample_data_i, // analog core result, from another domain
   output wire converter_power_on_o, // powers the analog core
   output wire sample_phase_o, // analog core sampling
   output wire irq_o // interrupt toward the converter vector
);
   localparam ST_IDLE = 3'h1;
   localparam ST_SAMPLE = 3'h2;
   localparam ST_CONVERT = 3'h4;

   // conversion state
   reg [2:0] state_reg;
   reg [2:0] state_next;
   // start bit level and edge tracking
   reg start_reg;
   reg start_next;
   reg start_armed_reg;
   reg start_armed_next;
   // control fields
   reg power_reg;
   reg power_next;
   reg irq_flag_reg;
   reg irq_flag_next;
   reg irq_en_reg;
   reg irq_en_next;
   reg master_en_reg;
   reg master_en_next;
   reg irq_out_reg;
   reg [2:0] div_sel_reg;
   reg [2:0] div_sel_next;
   // conversion clock divider and tick counter
   reg [6:0] div_cnt_reg;
   reg [6:0] div_cnt_next;
   reg [3:0] tick_cnt_reg;
   reg [3:0] tick_cnt_next;
   // result capture and read port
   reg [9:0] result_reg;
   reg [9:0] result_next;
   reg [9:0] samp_meta_reg;
   reg [9:0] samp_sync_reg;
   reg [7:0] rdata_next;

   // strobe aimed at one register index
   function reg_hit;
      input strobe;
      input [1:0] addr;
      input [1:0] index;
      begin
         reg_hit = strobe && (addr == index);
      end
   endfunction

   // terminal count of the divider for select code n is 2^n - 1;
   // code 7 wraps 128 to 0 in seven bits, which leaves 127 as wanted
   function [6:0] div_limit;
      input [2:0] sel;
      begin
         div_limit = (7'h01 << sel) - 7'h01;
      end
   endfunction

   wire idle = state_reg[0];
   wire busy = ~idle;
   wire wr_a = reg_hit(wr_i, addr_i, `ADDR_CTRL_A);
   wire wr_b = reg_hit(wr_i, addr_i, `ADDR_CTRL_B);
   // full low-high-low pulse seen: falling edge after an armed rise
   wire start_go = power_reg && start_armed_reg && start_reg && !start_next;
   wire adc_tick = (div_cnt_reg == div_limit(div_sel_reg));
   wire sample_end = adc_tick && (tick_cnt_reg == (`SAMPLE_TICKS - 4'h1));
   wire last_tick = adc_tick && (tick_cnt_reg == (`TOTAL_TICKS - 4'h1));
   // a conversion cut by power-off neither sets the flag nor loads a result
   wire done = state_reg[2] && last_tick && power_next;

   assign converter_power_on_o = power_reg;
   assign sample_phase_o = state_reg[1];
   assign irq_o = irq_out_reg;

   always @* begin
      start_next = start_reg;
      power_next = power_reg;
      irq_en_next = irq_en_reg;
      master_en_next = master_en_reg;
      div_sel_next = div_sel_reg;
      if (wr_a) begin
         start_next = wdata_i[`BIT_START];
         power_next = wdata_i[`BIT_POWER];
         irq_en_next = wdata_i[`BIT_IRQ_EN];
         master_en_next = wdata_i[`BIT_MASTER_EN];
      end
      if (wr_b)
         div_sel_next = wdata_i[`DIV_MSB:`DIV_LSB];
   end

   // arm only on a rise that follows a low level
   always @* begin
      start_armed_next = start_armed_reg;
      if (!start_reg && start_next)
         start_armed_next = 1'h1;
      else if (!start_next)
         start_armed_next = 1'h0;
   end

   // hardware set wins over a software clear in the same cycle
   always @* begin
      irq_flag_next = irq_flag_reg;
      if (done)
         irq_flag_next = 1'h1;
      else if (wr_a && !wdata_i[`BIT_IRQ_FLAG])
         irq_flag_next = 1'h0;
   end

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (start_go)
               state_next = ST_SAMPLE;
         end
         ST_SAMPLE: begin
            if (sample_end)
               state_next = ST_CONVERT;
         end
         ST_CONVERT: begin
            if (last_tick)
               state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
      // power-off aborts in the same edge that drops the power output
      if (!power_next)
         state_next = ST_IDLE;
   end

   always @* begin
      if (idle || adc_tick)
         div_cnt_next = 7'h00;
      else
         div_cnt_next = div_cnt_reg + 7'h01;
      if (idle)
         tick_cnt_next = 4'h0;
      else if (adc_tick)
         tick_cnt_next = tick_cnt_reg + 4'h1;
      else
         tick_cnt_next = tick_cnt_reg;
   end

   always @* begin
      result_next = result_reg;
      if (done)
         result_next = samp_sync_reg & `FULL_SCALE;
   end

   always @* begin
      rdata_next = 8'h00;
      if (rd_i) begin
         case (addr_i)
            `ADDR_CTRL_A: rdata_next = {start_reg, busy, power_reg, irq_flag_reg,
                                        irq_en_reg, master_en_reg, 2'h0};
            `ADDR_CTRL_B: rdata_next = {5'h00, div_sel_reg};
            `ADDR_RES_HI: rdata_next = {6'h00, result_reg[9:8]};
            `ADDR_RES_LO: rdata_next = result_reg[7:0];
            default: rdata_next = 8'h00;
         endcase
      end
   end

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= ST_IDLE;
         start_reg <= 1'h0;
         start_armed_reg <= 1'h0;
      end else begin
         state_reg <= state_next;
         start_reg <= start_next;
         start_armed_reg <= start_armed_next;
      end
   end

   // interrupt output is registered from the next values, so it moves with its fields
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         power_reg <= 1'h0;
         irq_flag_reg <= 1'h0;
         irq_en_reg <= 1'h0;
         master_en_reg <= 1'h0;
         irq_out_reg <= 1'h0;
         div_sel_reg <= 3'h0;
      end else begin
         power_reg <= power_next;
         irq_flag_reg <= irq_flag_next;
         irq_en_reg <= irq_en_next;
         master_en_reg <= master_en_next;
         irq_out_reg <= irq_flag_next && irq_en_next && master_en_next;
         div_sel_reg <= div_sel_next;
      end
   end

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_cnt_reg <= 7'h00;
         tick_cnt_reg <= 4'h0;
      end else begin
         div_cnt_reg <= div_cnt_next;
         tick_cnt_reg <= tick_cnt_next;
      end
   end

   // two-flop synchroniser for the analog core result
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         samp_meta_reg <= 10'h000;
         samp_sync_reg <= 10'h000;
      end else begin
         samp_meta_reg <= sample_data_i;
         samp_sync_reg <= samp_meta_reg;
      end
   end

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         result_reg <= 10'h000;
         rdata_o <= 8'h00;
      end else begin
         result_reg <= result_next;
         rdata_o <= rdata_next;
      end
   end
endmodule // adc_conversion_sequencer

//--- adc_seq_consts.vh
// constants for the conversion sequencer: register indices, field positions, timing
// included by the sequencer module only
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH
`define ADDR_CTRL_A 2'h0
`define ADDR_CTRL_B 2'h1
`define ADDR_RES_HI 2'h2
`define ADDR_RES_LO 2'h3
`define BIT_START 7
`define BIT_BUSY 6
`define BIT_POWER 5
`define BIT_IRQ_FLAG 4
`define BIT_IRQ_EN 3
`define BIT_MASTER_EN 2
`define DIV_LSB 0
`define DIV_MSB 2
`define SAMPLE_TICKS 4'h4
`define TOTAL_TICKS 4'hE
`define FULL_SCALE 10'h3FF
`endif

//--- adc_seq_chk.sv
// port checker for the conversion sequencer
// sees only the sequencer ports; attached by the bind below
`timescale 1ns/100ps
module adc_seq_chk (
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire [1:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   input wire [9:0] sample_data_i,
   input wire converter_power_on_o,
   input wire sample_phase_o,
   input wire irq_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   samp_len_a: assert property ($rose(sample_phase_o) |->
      (sample_phase_o || !converter_power_on_o)[*4]) else $error("sampling too short");
   pwr_gate_a: assert property (!converter_power_on_o |-> !sample_phase_o)
      else $error("sampling while powered off");
   rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data outside read slot");
   pwr_wr_a: assert property (wr_i && addr_i == 2'h0 |=>
      converter_power_on_o == $past(wdata_i[5])) else $error("power bit not taken");
   irq_en_a: assert property (wr_i && addr_i == 2'h0 && wdata_i[3:2] != 2'h3 |=> !irq_o)
      else $error("interrupt while disabled");
   start_cause_a: assert property ($rose(sample_phase_o) |->
      $past(wr_i) && $past(addr_i) == 2'h0) else $error("sampling without start write");
   rd_pwr_a: assert property (rd_i && addr_i == 2'h0 |=>
      rdata_o[5] == converter_power_on_o) else $error("power bit readback");
   res_width_a: assert property (rd_i && addr_i == 2'h2 |=> rdata_o[7:2] == 6'h00)
      else $error("result wider than ten bits");
endmodule // adc_seq_chk

bind adc_conversion_sequencer adc_seq_chk adc_seq_chk_inst (.clk_sys_i, .rst_n_i,
   .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sample_data_i, .converter_power_on_o,
   .sample_phase_o, .irq_o);

//--- adc_conversion_sequencer_tb.sv
// self-checking bench for the conversion sequencer
// drives the register port at rising edges; analog result held steady per conversion
`timescale 1ns/100ps
module adc_conversion_sequencer_tb;
   reg clk_sys_i, rst_n_i, wr_i, rd_i, chk;
   reg [1:0] addr_i;
   reg [7:0] wdata_i, exp_q, exp_r;
   reg [9:0] sample_data_i;
   wire [7:0] rdata_o;
   wire converter_power_on_o, sample_phase_o, irq_o;
   integer error_cnt, comparisons, s;
   adc_conversion_sequencer adc_conversion_sequencer_inst (.clk_sys_i, .rst_n_i, .addr_i,
      .wdata_i, .wr_i, .rd_i, .rdata_o, .sample_data_i, .converter_power_on_o,
      .sample_phase_o, .irq_o);
   task check(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input [1:0] a, input [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      {wr_i, rd_i} <= 2'h2;
      @(posedge clk_sys_i);
   endtask
   task rd(input [1:0] a, input [7:0] e);
      addr_i <= a;
      exp_q <= e;
      {wr_i, rd_i} <= 2'h1;
      @(posedge clk_sys_i);
   endtask
   task idle(input integer n);
      {wr_i, rd_i} <= 2'h0;
      repeat (n) @(posedge clk_sys_i);
   endtask
   task end_sim;
      if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // one conversion at divider code c; lo is the idle control value
   task run(input [2:0] c, input [7:0] lo);
      sample_data_i <= 10'h3FF >> c;
      wr(2'h1, {5'h00, c});
      wr(2'h0, lo | 8'h80);
      wr(2'h0, lo);
      rd(2'h0, lo | 8'h40);
      idle((14 << c) - 2);
      rd(2'h0, lo | 8'h40);
      rd(2'h0, lo | 8'h10);
      check({7'h00, irq_o}, {7'h00, lo[3] & lo[2]});
      rd(2'h2, {6'h00, sample_data_i[9:8]});
      rd(2'h3, sample_data_i[7:0]);
   endtask
   // read data stands in the cycle after the strobe
   always @(posedge clk_sys_i) begin
      if (chk) check(rdata_o, exp_r);
      chk <= rd_i;
      exp_r <= exp_q;
   end
   initial begin
      clk_sys_i = 0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      {rst_n_i, wr_i, rd_i, chk, addr_i, wdata_i, exp_q, exp_r, sample_data_i} = 0;
      error_cnt = 0;
      comparisons = 0;
      repeat (12) @(posedge clk_sys_i);
      rst_n_i <= 1;
      for (s = 0; s < 4; s++) rd(s[1:0], 8'h00);
      wr(2'h0, 8'h80);
      wr(2'h0, 8'h00);
      rd(2'h0, 8'h00);
      wr(2'h0, 8'h2C);
      idle(4);
      for (s = 0; s < 8; s++) run(s[2:0], 8'h2C);
      run(3'h1, 8'h28);
      wr(2'h0, 8'hA8);
      wr(2'h0, 8'h28);
      wr(2'h0, 8'h08);
      idle(40);
      rd(2'h0, 8'h08);
      idle(2);
      end_sim;
   end
endmodule // adc_conversion_sequencer_tb
